// >>> rtl/led_current_pulse_config_regs.sv
// led current and slot a pulse configuration register bank
// assumes the serial control engine hands over decoded accesses
// on reg_* one cycle at a time, synchronous to clk
`timescale 1ns/1ps
`default_nettype none

`include "led_cfg_params.svh"

module led_current_pulse_config_regs
    import led_cfg_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // register access from the serial control engine
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    output logic             reg_rd_valid,
    // first led settings held in the neighbouring bank
    input  wire logic [3:0]  first_led_coarse_code,
    input  wire logic        first_led_scale_sel,
    // slot a led choice held in the neighbouring bank
    input  wire logic [1:0]  slot_a_led_choice,
    // second led fields
    output logic             second_led_scale_sel,
    output logic [3:0]       second_led_coarse_code,
    output logic [4:0]       second_led_fine_code,
    // first led fine field
    output logic [4:0]       first_led_fine_code,
    // slot a fields
    output logic [15:0]      slot_a_led_mode_word,
    output logic [7:0]       slot_a_pulse_count,
    // peak targets, 50 na units
    output logic [`PEAK_W-1:0] first_emitter_peak,
    output logic [`PEAK_W-1:0] second_emitter_peak,
    output logic [`PEAK_W-1:0] slot_a_peak_target,
    output logic             slot_a_choice_valid
);

    // ******************************************************************
    // state
    // ******************************************************************
    bank_s st;        // every register of the bank
    bank_s next_st;   // value for the next edge

    // reset image of the whole bank
    localparam bank_s BANK_RESET = '{
        scale_coarse : `RST_SECOND_SCALE_COARSE,
        fine_adjust  : `RST_FINE_ADJUST,
        mode_word    : `RST_SLOT_A_MODE,
        pulses       : `RST_SLOT_A_PULSES,
        rdata        : 16'h0000,
        rd_valid     : 1'b0,
        slot_a_peak  : '0,
        slot_a_valid : 1'b0
    };

    logic [`PEAK_W-1:0] first_peak;    // first led calculator result
    logic [`PEAK_W-1:0] second_peak;   // second led calculator result

    // ******************************************************************
    // peak calculators
    // ******************************************************************
    // one calculator per led; the first led codes partly come from outside
    led_peak_calc first_calc (
        .clk         (clk),
        .srst        (srst),
        .coarse_code (first_led_coarse_code),
        .fine_code   (st.fine_adjust[`FIRST_FINE_MSB:`FIRST_FINE_LSB]),
        .scale_sel   (first_led_scale_sel),
        .peak_target (first_peak)
    );

    led_peak_calc second_calc (
        .clk         (clk),
        .srst        (srst),
        .coarse_code (st.scale_coarse[`SECOND_COARSE_MSB:`SECOND_COARSE_LSB]),
        .fine_code   (st.fine_adjust[`SECOND_FINE_MSB:`SECOND_FINE_LSB]),
        .scale_sel   (st.scale_coarse[`SECOND_SCALE_BIT]),
        .peak_target (second_peak)
    );

    // ******************************************************************
    // next state
    // ******************************************************************
    // writes store all 16 bits, reserved ones included, so software
    // can program the fixed values they need; reads return the value
    // held before any write in the same cycle
    always_comb begin
        next_st = st;
        next_st.rd_valid = 1'b0;

        // register writes, unmapped addresses ignored
        if (reg_wr) begin
            case (reg_addr)
                `ADDR_SECOND_SCALE_COARSE: begin
                    next_st.scale_coarse = reg_wdata;
                end
                `ADDR_FINE_ADJUST: begin
                    next_st.fine_adjust = reg_wdata;
                end
                `ADDR_SLOT_A_MODE: begin
                    next_st.mode_word = reg_wdata;
                end
                `ADDR_SLOT_A_PULSES: begin
                    next_st.pulses = reg_wdata;
                end
                default: begin
                    next_st.scale_coarse = st.scale_coarse;   // nothing mapped here
                end
            endcase
        end

        // register reads, unmapped addresses answer zero
        if (reg_rd) begin
            next_st.rd_valid = 1'b1;
            case (reg_addr)
                `ADDR_SECOND_SCALE_COARSE: begin
                    next_st.rdata = st.scale_coarse;
                end
                `ADDR_FINE_ADJUST: begin
                    next_st.rdata = st.fine_adjust;
                end
                `ADDR_SLOT_A_MODE: begin
                    next_st.rdata = st.mode_word;
                end
                `ADDR_SLOT_A_PULSES: begin
                    next_st.rdata = st.pulses;
                end
                default: begin
                    next_st.rdata = 16'h0000;
                end
            endcase
        end

        // slot a led choice; reserved codes drive no led
        case (slot_a_led_choice)
            LED_CHOICE_FIRST: begin
                next_st.slot_a_peak  = first_peak;
                next_st.slot_a_valid = 1'b1;
            end
            LED_CHOICE_SECOND: begin
                next_st.slot_a_peak  = second_peak;
                next_st.slot_a_valid = 1'b1;
            end
            default: begin
                next_st.slot_a_peak  = '0;
                next_st.slot_a_valid = 1'b0;
            end
        endcase
    end

    // ******************************************************************
    // state register
    // ******************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= BANK_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ******************************************************************
    // outputs
    // ******************************************************************
    assign reg_rdata              = st.rdata;
    assign reg_rd_valid           = st.rd_valid;
    assign second_led_scale_sel   = st.scale_coarse[`SECOND_SCALE_BIT];
    assign second_led_coarse_code = st.scale_coarse[`SECOND_COARSE_MSB:`SECOND_COARSE_LSB];
    assign second_led_fine_code   = st.fine_adjust[`SECOND_FINE_MSB:`SECOND_FINE_LSB];
    assign first_led_fine_code    = st.fine_adjust[`FIRST_FINE_MSB:`FIRST_FINE_LSB];
    assign slot_a_led_mode_word   = st.mode_word;
    assign slot_a_pulse_count     = st.pulses[`PULSE_COUNT_MSB:`PULSE_COUNT_LSB];
    assign first_emitter_peak     = first_peak;
    assign second_emitter_peak    = second_peak;
    assign slot_a_peak_target     = st.slot_a_peak;
    assign slot_a_choice_valid    = st.slot_a_valid;

endmodule : led_current_pulse_config_regs

`default_nettype wire

// >>> inc/led_cfg_params.svh
// constants of the led current and pulse configuration bank
// assumes inclusion by bare name from the package and from design files
`ifndef LED_CFG_PARAMS_SVH
`define LED_CFG_PARAMS_SVH

// ******************************************************************
// register offsets, one 16-bit register per address, 8-bit index
// ******************************************************************
`define ADDR_SECOND_SCALE_COARSE 8'h24
`define ADDR_FINE_ADJUST         8'h25
`define ADDR_SLOT_A_MODE         8'h30
`define ADDR_SLOT_A_PULSES       8'h31

// ******************************************************************
// reset values of whole registers
// ******************************************************************
`define RST_SECOND_SCALE_COARSE  16'h3000
`define RST_FINE_ADJUST          16'h630c
`define RST_SLOT_A_MODE          16'h0320
`define RST_SLOT_A_PULSES        16'h0818

// recommended software values, kept here for firmware reference
`define REC_SLOT_A_MODE          16'h0319
`define REC_SLOT_A_PULSES        8'h06
`define REC_SLOT_A_PULSE_LOW     8'h13

// ******************************************************************
// field positions
// ******************************************************************
`define SECOND_SCALE_BIT         13
`define SECOND_COARSE_MSB        3
`define SECOND_COARSE_LSB        0
`define SECOND_FINE_MSB          10
`define SECOND_FINE_LSB          6
`define FIRST_FINE_MSB           4
`define FIRST_FINE_LSB           0
`define PULSE_COUNT_MSB          15
`define PULSE_COUNT_LSB          8

// ******************************************************************
// fixed point terms: coarse in 0.5 ma, fine in 1/1000, scale in 1/10
// ******************************************************************
`define COARSE_BASE              10'd56
`define COARSE_STEP              10'd31
`define FINE_BASE                11'd710
`define FINE_STEP                11'd24
`define SCALE_BASE               4'd4
`define SCALE_STEP               4'd6
`define PEAK_W                   23

`endif

// >>> inc/led_cfg_pkg.sv
// types and term arithmetic of the led configuration bank
// assumes led_cfg_params.svh is on the include path
`include "led_cfg_params.svh"

package led_cfg_pkg;

    // slot led choice codes, 0 and 3 are reserved
    typedef enum logic [1:0] {
        LED_CHOICE_NONE   = 2'b00,
        LED_CHOICE_FIRST  = 2'b01,
        LED_CHOICE_SECOND = 2'b10,
        LED_CHOICE_RSVD   = 2'b11
    } led_choice_e;

    typedef logic [15:0]          reg_word_t;  // one register word
    typedef logic [`PEAK_W-1:0]   peak_t;      // peak target, 50 na units

    // whole state of the register bank
    typedef struct packed {
        reg_word_t scale_coarse;   // second led scale and coarse
        reg_word_t fine_adjust;    // fine codes of both leds
        reg_word_t mode_word;      // slot a led mode word
        reg_word_t pulses;         // slot a pulse count register
        reg_word_t rdata;          // read answer
        logic      rd_valid;       // read answer strobe
        peak_t     slot_a_peak;    // peak of the led chosen for slot a
        logic      slot_a_valid;   // choice names a real led
    } bank_s;

    // state of one peak calculator
    typedef struct packed {
        peak_t peak;
    } calc_s;

    // coarse term, 0.5 ma units: 28 + 15.5 * code
    function automatic logic [9:0] coarse_term(input logic [3:0] code);
        coarse_term = `COARSE_BASE + `COARSE_STEP * {6'h00, code};
    endfunction : coarse_term

    // fine term, 1/1000 units: 0.71 + 0.024 * code
    function automatic logic [10:0] fine_term(input logic [4:0] code);
        fine_term = `FINE_BASE + `FINE_STEP * {6'h00, code};
    endfunction : fine_term

    // scale term, 1/10 units: 0.4 + 0.6 * bit
    function automatic logic [3:0] scale_term(input logic sel);
        scale_term = `SCALE_BASE + `SCALE_STEP * {3'h0, sel};
    endfunction : scale_term

endpackage : led_cfg_pkg

// >>> rtl/led_peak_calc.sv
// peak current target of one led from its three codes
// assumes codes are steady register outputs of the same clock
`timescale 1ns/1ps
`default_nettype none

`include "led_cfg_params.svh"

module led_peak_calc
    import led_cfg_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // current codes
    input  wire logic [3:0]  coarse_code,
    input  wire logic [4:0]  fine_code,
    input  wire logic        scale_sel,
    // result
    output logic [`PEAK_W-1:0] peak_target
);

    calc_s        st;        // registered state
    calc_s        next_st;   // next state
    logic [24:0]  product;   // full width product

    // ******************************************************************
    // product of the three terms, one cycle of latency
    // ******************************************************************
    // peak fits 23 bits: 521 * 1454 * 10 is below 2**23
    always_comb begin
        next_st = st;
        product = {15'h0000, coarse_term(coarse_code)}
                * {14'h0000, fine_term(fine_code)}
                * {21'h000000, scale_term(scale_sel)};
        next_st.peak = product[`PEAK_W-1:0];
    end

    // state register
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign peak_target = st.peak;

endmodule : led_peak_calc

`default_nettype wire

// >>> verif/led_cfg_checker.sv
// port checker of the led current and pulse configuration bank
// assumes binding onto led_current_pulse_config_regs, one clock
`timescale 1ns/1ps
`default_nettype none
module led_cfg_checker
    import led_cfg_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // register access
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_rd_valid,
    // codes and results
    input wire logic [3:0]  first_led_coarse_code,
    input wire logic        first_led_scale_sel,
    input wire logic [1:0]  slot_a_led_choice,
    input wire logic        second_led_scale_sel,
    input wire logic [3:0]  second_led_coarse_code,
    input wire logic [4:0]  second_led_fine_code,
    input wire logic [4:0]  first_led_fine_code,
    input wire logic [15:0] slot_a_led_mode_word,
    input wire logic [7:0]  slot_a_pulse_count,
    input wire logic [22:0] first_emitter_peak,
    input wire logic [22:0] second_emitter_peak,
    input wire logic [22:0] slot_a_peak_target,
    input wire logic        slot_a_choice_valid
);
    // own arithmetic, kept apart from the design's functions
    function automatic logic [22:0] pk(logic [3:0] c, logic [4:0] f, logic s);
        pk = (23'd56 + 23'd31 * c) * (23'd710 + 23'd24 * f) * (23'd4 + 23'd6 * s);
    endfunction : pk
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // ********************************
    // field and read timing, peak results and choice valid
    // ********************************
    AST_SCALE: assert property (reg_wr && reg_addr == 8'h24 |=>
        second_led_scale_sel == $past(reg_wdata[13])) else $error("scale bit wrong");
    AST_COARSE: assert property (reg_wr && reg_addr == 8'h24 |=>
        second_led_coarse_code == $past(reg_wdata[3:0])) else $error("coarse wrong");
    AST_FINE2: assert property (reg_wr && reg_addr == 8'h25 |=>
        second_led_fine_code == $past(reg_wdata[10:6])) else $error("fine2 wrong");
    AST_FINE1: assert property (reg_wr && reg_addr == 8'h25 |=>
        first_led_fine_code == $past(reg_wdata[4:0])) else $error("fine1 wrong");
    AST_MODE: assert property (reg_wr && reg_addr == 8'h30 |=>
        slot_a_led_mode_word == $past(reg_wdata)) else $error("mode word wrong");
    AST_PULSES: assert property (reg_wr && reg_addr == 8'h31 |=>
        slot_a_pulse_count == $past(reg_wdata[15:8])) else $error("pulse count wrong");
    AST_READ: assert property (reg_rd && !reg_wr && reg_addr == 8'h30 |=>
        reg_rd_valid && reg_rdata == slot_a_led_mode_word) else $error("readback wrong");
    AST_PEAK1: assert property (!$past(srst) |-> first_emitter_peak == pk(
        $past(first_led_coarse_code), $past(first_led_fine_code),
        $past(first_led_scale_sel))) else $error("first peak wrong");
    AST_PEAK2: assert property (!$past(srst) |-> second_emitter_peak == pk(
        $past(second_led_coarse_code), $past(second_led_fine_code),
        $past(second_led_scale_sel))) else $error("second peak wrong");
    AST_CHOICE: assert property (!$past(srst) && !$past(srst, 2) |->
        slot_a_choice_valid == ($past(slot_a_led_choice) inside {2'b01, 2'b10}))
        else $error("choice valid wrong");
    // covers of the main scenarios
    COV_WR: cover property (reg_wr && reg_addr == 8'h25);
    COV_RD: cover property (reg_rd && reg_wr);
    COV_SEL: cover property (slot_a_choice_valid && slot_a_led_choice == 2'b10);
endmodule : led_cfg_checker
bind led_current_pulse_config_regs led_cfg_checker u_chk (.*);
`default_nettype wire

// >>> verif/led_current_pulse_config_regs_bench.sv
// self-checking bench of the led configuration bank
// assumes the bound checker and a free-running 100 mhz clock
`timescale 1ns/1ps
`default_nettype none
module led_current_pulse_config_regs_bench
    import led_cfg_pkg::*;
;
    logic clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, reg_rd_valid;
    logic [7:0] reg_addr = 8'h00, slot_a_pulse_count;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, slot_a_led_mode_word;
    logic [3:0] first_led_coarse_code = 4'h0, second_led_coarse_code;
    logic first_led_scale_sel = 1'b0, second_led_scale_sel, slot_a_choice_valid;
    logic [1:0] slot_a_led_choice = 2'h0;
    logic [4:0] second_led_fine_code, first_led_fine_code;
    logic [22:0] first_emitter_peak, second_emitter_peak, slot_a_peak_target, e1, e2;
    int failures = 0;
    int comparisons = 0;
    led_current_pulse_config_regs u_dut (.*);
    // ********************************
    // helpers
    // ********************************
    initial begin
        forever #5 clk = ~clk;
    end
    function automatic logic [22:0] pk(logic [3:0] c, logic [4:0] f, logic s);
        pk = (23'd56 + 23'd31 * c) * (23'd710 + 23'd24 * f) * (23'd4 + 23'd6 * s);
    endfunction : pk
    task automatic check(input string what, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr
    // strobe held one edge, answer looked at in its single valid cycle
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(negedge clk);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge clk);
        reg_rd = 1'b0;
        check("rd_valid", reg_rd_valid, 1);
        check(what, reg_rdata, exp);
        // answer strobe is a single cycle, data stands until the next read
        @(negedge clk);
        check("rd_valid_low", reg_rd_valid, 0);
        check("rdata_held", reg_rdata, exp);
    endtask : rdchk
    task automatic end_sim;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    // ********************************
    // scenarios
    // ********************************
    task automatic t_reset;
        check("rdata_rst", reg_rdata, 16'h0000);
        check("rd_valid_rst", reg_rd_valid, 0);
        check("scale_rst", second_led_scale_sel, 1);
        check("fine2_rst", second_led_fine_code, 5'h0c);
        check("mode_rst", slot_a_led_mode_word, 16'h0320);
        check("pulses_rst", slot_a_pulse_count, 8'h08);
        rdchk(8'h24, 16'h3000, "r24");
        rdchk(8'h25, 16'h630c, "r25");
        rdchk(8'h30, 16'h0320, "r30");
        rdchk(8'h31, 16'h0818, "r31");
        rdchk(8'h26, 16'h0000, "unmapped");
        check("coarse", second_led_coarse_code, 0);
        check("fine1", first_led_fine_code, 5'h0c);
    endtask : t_reset
    // reserved bits set on purpose, unmapped write must leave all alone
    task automatic t_write;
        wr(8'h24, 16'h5aa9);
        wr(8'h25, 16'h0ab5);
        wr(8'h30, 16'h0319);
        wr(8'h31, 16'h0613);
        wr(8'h32, 16'hffff);
        rdchk(8'h24, 16'h5aa9, "w24");
        rdchk(8'h25, 16'h0ab5, "w25");
        rdchk(8'h31, 16'h0613, "w31");
        check("scale", second_led_scale_sel, 0);
        check("coarse", second_led_coarse_code, 4'h9);
        check("fine2", second_led_fine_code, 5'h0a);
        check("fine1", first_led_fine_code, 5'h15);
        check("mode", slot_a_led_mode_word, 16'h0319);
        check("pulses", slot_a_pulse_count, 8'h06);
    endtask : t_write
    // every choice code, reserved ones included
    task automatic t_peak;
        @(negedge clk);
        first_led_coarse_code = 4'hf;
        first_led_scale_sel = 1'b1;
        e1 = pk(4'hf, 5'h15, 1'b1);
        e2 = pk(4'h9, 5'h0a, 1'b0);
        for (int c = 0; c < 4; c++) begin
            slot_a_led_choice = c[1:0];
            repeat (3) @(negedge clk);
            check("peak1", first_emitter_peak, e1);
            check("peak2", second_emitter_peak, e2);
            check("valid", slot_a_choice_valid, c == 1 || c == 2);
            check("slot_peak", slot_a_peak_target, c == 1 ? e1 : c == 2 ? e2 : 0);
        end
    endtask : t_peak
    // read and write of one word at one edge: old value comes back
    task automatic t_same;
        @(negedge clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b11, 8'h30, 16'h1234};
        @(negedge clk);
        {reg_wr, reg_rd} = 2'b00;
        check("old", reg_rdata, 16'h0319);
        rdchk(8'h30, 16'h1234, "new");
    endtask : t_same
    initial begin
        repeat (4) @(negedge clk);
        srst = 1'b0;
        t_reset;
        t_write;
        t_peak;
        t_same;
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        t_reset;
        end_sim;
    end
    // watchdog far beyond the 73 cycles of the run
    initial begin
        #100000;
        failures++;
        end_sim;
    end
endmodule : led_current_pulse_config_regs_bench
`default_nettype wire
